// >>> cdr_frontend_output_config_regs.sv
`include "cdr_cfg_defs.svh"
`default_nettype none

// Overview of operation
// - signed 4-bit phase steps sampling by 1/32 UI above 5.65 Gbps
// - slice bit 7 picks normal or extended slice range
// - 7-bit slice word sets threshold; zero disables slice adjust
// - stage bit 7: 0 drives termination common mode, 1 floats it
// - stage select 00 limiter, 01 equalizer, 10 buffer; 11 unused
// - stage bit 4: 0 manual boost, 1 adaptive equalization
// - stage bits 3..0 give equalizer gain under manual control
// - control bit 5 squelches data, bit 4 disables data output
// - control bit 3 disables recovered clock output
// - control bit 2 cleared enables double-rate clock mode
// - control bit 1 inverts output data polarity
// - control bit 0 inverts output clock polarity
// - data swing bits 7..4 reset to 0xc; host avoids 0x1..0x3
// - clock swing bits 3..0 reset to 0xc; host avoids 0x1..0x3
// - all fields writable by host over the two-wire interface
module cdr_frontend_output_config_regs #(
	parameter int unsigned DEV_ADDR = 32'h0000_0040
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_out,
	output logic            o_sda_oe_n,
	input  wire logic       i_high_rate,
	output logic [3:0]      o_sample_phase,
	output logic            o_extended_slice,
	output logic [6:0]      o_slice_level,
	output logic            o_slice_enable,
	output logic            o_term_float,
	output logic [1:0]      o_input_select,
	output logic            o_auto_boost_on,
	output logic [3:0]      o_equalizer_gain,
	output logic            o_squelch,
	output logic            o_serial_out_off,
	output logic            o_recovered_clk_off,
	output logic            o_ddr_clk_on,
	output logic            o_data_invert,
	output logic            o_clk_invert,
	output logic [3:0]      o_data_swing,
	output logic [3:0]      o_clk_swing
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DEV_ADDR > 32'h0000_007f) begin : g_bad_addr
		$error("device address must fit in seven bits");
	end

	localparam logic [6:0] SLAVE_ADDR = DEV_ADDR[6:0];

	// ----------------------------------------------------------------
	// register read decode
	// ----------------------------------------------------------------
	logic [7:0] sample_phase_offset;
	logic [7:0] slice_threshold_ctrl;
	logic [7:0] input_stage_select;
	logic [7:0] output_control;
	logic [7:0] output_amplitude;

	// unmapped offsets read as zero
	function automatic logic [7:0] read_reg(input logic [7:0] addr);
		logic [7:0] value;
		value = 8'h00;
		case (addr)
			`OFS_SAMPLE_PHASE_OFFSET:  value = sample_phase_offset;
			`OFS_SLICE_THRESHOLD_CTRL: value = slice_threshold_ctrl;
			`OFS_INPUT_STAGE_SELECT:   value = input_stage_select;
			`OFS_OUTPUT_CONTROL:       value = output_control;
			`OFS_OUTPUT_AMPLITUDE:     value = output_amplitude;
			default:                   value = 8'h00;
		endcase
		return value;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pin_raw;
	logic [1:0] pin_level;
	logic       scl;
	logic       sda;

	assign pin_raw = {i_scl, i_sda};
	assign scl     = pin_level[1];
	assign sda     = pin_level[0];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			pin_sync #(
				.RESET_LEVEL(1'b1)
			) u_sync (
				.i_clk   (i_clk),
				.i_reset (i_reset),
				.i_pin   (pin_raw[gi]),
				.o_level (pin_level[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// bus event detection
	// ----------------------------------------------------------------
	logic scl_q;
	logic sda_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise  = scl & ~scl_q;
	assign scl_fall  = ~scl & scl_q;
	// sda moving while scl is high frames a transfer
	assign bus_start = scl & scl_q & sda_q & ~sda;
	assign bus_stop  = scl & scl_q & ~sda_q & sda;

	// ----------------------------------------------------------------
	// serial protocol engine
	// ----------------------------------------------------------------
	cdr_cfg_pkg::serial_state_e state;
	logic [3:0]                 bit_cnt;
	logic [7:0]                 shift;
	logic [7:0]                 reg_ptr;
	logic                       read_dir;
	logic                       host_ack;
	logic                       wr_stb;
	logic [7:0]                 wr_addr;
	logic [7:0]                 wr_data;
	logic [7:0]                 rd_byte;

	// always_comb also follows the registers read inside the function
	always_comb begin
		rd_byte = read_reg(reg_ptr);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state      <= cdr_cfg_pkg::ST_IDLE;
			bit_cnt    <= 4'h0;
			shift      <= 8'h00;
			reg_ptr    <= 8'h00;
			read_dir   <= 1'b0;
			host_ack   <= 1'b0;
			wr_stb     <= 1'b0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			o_sda_oe_n <= 1'b1;
		end else begin
			wr_stb <= 1'b0;
			if (bus_stop) begin
				state      <= cdr_cfg_pkg::ST_IDLE;
				o_sda_oe_n <= 1'b1;
			end else if (bus_start) begin
				// also covers a repeated start
				state      <= cdr_cfg_pkg::ST_ADDR;
				bit_cnt    <= 4'h0;
				o_sda_oe_n <= 1'b1;
			end else begin
				case (state)
					cdr_cfg_pkg::ST_IDLE: begin
						o_sda_oe_n <= 1'b1;
					end
					cdr_cfg_pkg::ST_ADDR: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall &&
							bit_cnt == `I2C_BITS_PER_BYTE) begin
							if (shift[7:1] == SLAVE_ADDR) begin
								read_dir   <= shift[0];
								o_sda_oe_n <= 1'b0;
								state      <= cdr_cfg_pkg::ST_ADDR_ACK;
							end else begin
								// another slave is addressed
								state <= cdr_cfg_pkg::ST_IDLE;
							end
						end
					end
					cdr_cfg_pkg::ST_ADDR_ACK: begin
						if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (read_dir) begin
								shift      <= rd_byte;
								reg_ptr    <= reg_ptr + 8'h01;
								o_sda_oe_n <= rd_byte[7];
								state      <= cdr_cfg_pkg::ST_RDATA;
							end else begin
								o_sda_oe_n <= 1'b1;
								state      <= cdr_cfg_pkg::ST_REG;
							end
						end
					end
					cdr_cfg_pkg::ST_REG: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall &&
							bit_cnt == `I2C_BITS_PER_BYTE) begin
							reg_ptr    <= shift;
							o_sda_oe_n <= 1'b0;
							state      <= cdr_cfg_pkg::ST_REG_ACK;
						end
					end
					cdr_cfg_pkg::ST_REG_ACK: begin
						if (scl_fall) begin
							bit_cnt    <= 4'h0;
							o_sda_oe_n <= 1'b1;
							state      <= cdr_cfg_pkg::ST_WDATA;
						end
					end
					cdr_cfg_pkg::ST_WDATA: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall &&
							bit_cnt == `I2C_BITS_PER_BYTE) begin
							wr_stb     <= 1'b1;
							wr_addr    <= reg_ptr;
							wr_data    <= shift;
							reg_ptr    <= reg_ptr + 8'h01;
							o_sda_oe_n <= 1'b0;
							state      <= cdr_cfg_pkg::ST_WDATA_ACK;
						end
					end
					cdr_cfg_pkg::ST_WDATA_ACK: begin
						if (scl_fall) begin
							bit_cnt    <= 4'h0;
							o_sda_oe_n <= 1'b1;
							state      <= cdr_cfg_pkg::ST_WDATA;
						end
					end
					cdr_cfg_pkg::ST_RDATA: begin
						if (scl_fall) begin
							if (bit_cnt == `I2C_LAST_BIT) begin
								o_sda_oe_n <= 1'b1;
								state      <= cdr_cfg_pkg::ST_RDATA_ACK;
							end else begin
								bit_cnt    <= bit_cnt + 4'h1;
								shift      <= {shift[6:0], 1'b0};
								o_sda_oe_n <= shift[6];
							end
						end
					end
					cdr_cfg_pkg::ST_RDATA_ACK: begin
						if (scl_rise) begin
							host_ack <= ~sda;
						end else if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (host_ack) begin
								shift      <= rd_byte;
								reg_ptr    <= reg_ptr + 8'h01;
								o_sda_oe_n <= rd_byte[7];
								state      <= cdr_cfg_pkg::ST_RDATA;
							end else begin
								// nack ends the read burst
								state <= cdr_cfg_pkg::ST_IDLE;
							end
						end
					end
					default: begin
						o_sda_oe_n <= 1'b1;
						state      <= cdr_cfg_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge i_clk) begin
		o_sda_out <= 1'b0;
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sample_phase_offset  <= `RST_SAMPLE_PHASE_OFFSET;
			slice_threshold_ctrl <= `RST_SLICE_THRESHOLD_CTRL;
			input_stage_select   <= `RST_INPUT_STAGE_SELECT;
			output_control       <= `RST_OUTPUT_CONTROL;
			output_amplitude     <= `RST_OUTPUT_AMPLITUDE;
		end else if (wr_stb) begin
			// reserved bits masked so they read back zero
			case (wr_addr)
				`OFS_SAMPLE_PHASE_OFFSET: begin
					sample_phase_offset <=
						wr_data & `MASK_SAMPLE_PHASE_OFFSET;
				end
				`OFS_SLICE_THRESHOLD_CTRL: begin
					slice_threshold_ctrl <=
						wr_data & `MASK_SLICE_THRESHOLD_CTRL;
				end
				`OFS_INPUT_STAGE_SELECT: begin
					// code 11 is stored as written
					input_stage_select <=
						wr_data & `MASK_INPUT_STAGE_SELECT;
				end
				`OFS_OUTPUT_CONTROL: begin
					output_control <=
						wr_data & `MASK_OUTPUT_CONTROL;
				end
				`OFS_OUTPUT_AMPLITUDE: begin
					// invalid swing codes are not trapped here
					output_amplitude <=
						wr_data & `MASK_OUTPUT_AMPLITUDE;
				end
				default: begin
					sample_phase_offset <= sample_phase_offset;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// front-end controls
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_sample_phase <= 4'h0;
		end else if (i_high_rate) begin
			// twos complement offset, 1/32 UI per count
			o_sample_phase <=
				sample_phase_offset[`POS_PHASE_MSB:0];
		end else begin
			o_sample_phase <= 4'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_extended_slice <= 1'b0;
			o_slice_level    <= 7'h00;
			o_slice_enable   <= 1'b0;
		end else begin
			o_extended_slice <=
				slice_threshold_ctrl[`POS_SLICE_EXT];
			o_slice_level <=
				slice_threshold_ctrl[`POS_SLICE_MSB:0];
			o_slice_enable <=
				|slice_threshold_ctrl[`POS_SLICE_MSB:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_term_float     <= 1'b0;
			o_input_select   <= cdr_cfg_pkg::STAGE_LIMITER;
			o_auto_boost_on  <= 1'b0;
			o_equalizer_gain <= 4'h0;
		end else begin
			o_term_float <=
				input_stage_select[`POS_TERM_FLOAT];
			o_input_select <=
				input_stage_select[`POS_SEL_MSB:`POS_SEL_LSB];
			// rate qualification is left to the host
			o_auto_boost_on <=
				input_stage_select[`POS_AUTO_BOOST];
			o_equalizer_gain <=
				input_stage_select[`POS_GAIN_MSB:0];
		end
	end

	// ----------------------------------------------------------------
	// output stage controls
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_squelch           <= 1'b0;
			o_serial_out_off    <= 1'b0;
			o_recovered_clk_off <= 1'b0;
			o_ddr_clk_on        <= 1'b1;
			o_data_invert       <= 1'b0;
			o_clk_invert        <= 1'b0;
		end else begin
			o_squelch        <= output_control[`POS_SQUELCH];
			o_serial_out_off <= output_control[`POS_SERIAL_OFF];
			o_recovered_clk_off <= output_control[`POS_RCLK_OFF];
			// enable is active when the bit is clear
			o_ddr_clk_on  <= ~output_control[`POS_DDR_OFF];
			o_data_invert <= output_control[`POS_DATA_INV];
			o_clk_invert  <= output_control[`POS_CLK_INV];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_data_swing <=
				4'(`RST_OUTPUT_AMPLITUDE >> `POS_DSWING_LSB);
			o_clk_swing  <= 4'hc;
		end else begin
			o_data_swing <=
				output_amplitude[`POS_DSWING_MSB:`POS_DSWING_LSB];
			o_clk_swing <=
				output_amplitude[`POS_CSWING_MSB:0];
		end
	end

endmodule

`default_nettype wire

// >>> cdr_cfg_defs.svh
`ifndef CDR_CFG_DEFS_SVH
`define CDR_CFG_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_SAMPLE_PHASE_OFFSET  8'h14
`define OFS_SLICE_THRESHOLD_CTRL 8'h15
`define OFS_INPUT_STAGE_SELECT   8'h16
`define OFS_OUTPUT_CONTROL       8'h1e
`define OFS_OUTPUT_AMPLITUDE     8'h1f

// ----------------------------------------------------------------
// writable bits; reserved bits are held at zero
// ----------------------------------------------------------------
`define MASK_SAMPLE_PHASE_OFFSET  8'h0f
`define MASK_SLICE_THRESHOLD_CTRL 8'hff
`define MASK_INPUT_STAGE_SELECT   8'hff
`define MASK_OUTPUT_CONTROL       8'h3f
`define MASK_OUTPUT_AMPLITUDE     8'hff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SAMPLE_PHASE_OFFSET  8'h00
`define RST_SLICE_THRESHOLD_CTRL 8'h00
`define RST_INPUT_STAGE_SELECT   8'h00
`define RST_OUTPUT_CONTROL       8'h00
`define RST_OUTPUT_AMPLITUDE     8'hcc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POS_PHASE_MSB     3
`define POS_SLICE_EXT     7
`define POS_SLICE_MSB     6
`define POS_TERM_FLOAT    7
`define POS_SEL_MSB       6
`define POS_SEL_LSB       5
`define POS_AUTO_BOOST    4
`define POS_GAIN_MSB      3
`define POS_SQUELCH       5
`define POS_SERIAL_OFF    4
`define POS_RCLK_OFF      3
`define POS_DDR_OFF       2
`define POS_DATA_INV      1
`define POS_CLK_INV       0
`define POS_DSWING_MSB    7
`define POS_DSWING_LSB    4
`define POS_CSWING_MSB    3

// ----------------------------------------------------------------
// serial interface
// ----------------------------------------------------------------
`define I2C_BITS_PER_BYTE 4'h8
`define I2C_LAST_BIT      4'h7

`endif

// >>> cdr_cfg_pkg.sv
`default_nettype none

package cdr_cfg_pkg;

	typedef enum logic [8:0] {
		ST_IDLE      = 9'b000000001,
		ST_ADDR      = 9'b000000010,
		ST_ADDR_ACK  = 9'b000000100,
		ST_REG       = 9'b000001000,
		ST_REG_ACK   = 9'b000010000,
		ST_WDATA     = 9'b000100000,
		ST_WDATA_ACK = 9'b001000000,
		ST_RDATA     = 9'b010000000,
		ST_RDATA_ACK = 9'b100000000
	} serial_state_e;

	typedef enum logic [1:0] {
		STAGE_LIMITER   = 2'h0,
		STAGE_EQUALIZER = 2'h1,
		STAGE_BUFFER    = 2'h2,
		STAGE_UNDEFINED = 2'h3
	} input_stage_e;

endpackage

`default_nettype wire

// >>> pin_sync.sv
`default_nettype none

// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_pin,
	output logic      o_level
);

	logic meta;
	logic stage2;
	logic stage3;

	// meta feeds stage2 only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			meta   <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			stage3 <= RESET_LEVEL;
		end else begin
			meta   <= i_pin;
			stage2 <= meta;
			stage3 <= stage2;
		end
	end

	// a change counts only once two stages agree
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_level <= RESET_LEVEL;
		end else if (stage2 == stage3) begin
			o_level <= stage3;
		end
	end

endmodule

`default_nettype wire

// >>> cdr_cfg_checker.sv
`default_nettype none

module cdr_cfg_checker (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_scl,
	input wire logic       o_sda_out,
	input wire logic       o_sda_oe_n,
	input wire logic       i_high_rate,
	input wire logic [3:0] o_sample_phase,
	input wire logic       o_extended_slice,
	input wire logic [6:0] o_slice_level,
	input wire logic       o_slice_enable,
	input wire logic       o_term_float,
	input wire logic [1:0] o_input_select,
	input wire logic       o_auto_boost_on,
	input wire logic [3:0] o_equalizer_gain,
	input wire logic       o_squelch,
	input wire logic       o_serial_out_off,
	input wire logic       o_recovered_clk_off,
	input wire logic       o_ddr_clk_on,
	input wire logic       o_data_invert,
	input wire logic       o_clk_invert,
	input wire logic [3:0] o_data_swing,
	input wire logic [3:0] o_clk_swing
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [30:0] cfg;

	// phase left out: it also follows the rate qualifier
	assign cfg = {o_extended_slice, o_slice_level, o_slice_enable,
		o_term_float, o_input_select, o_auto_boost_on, o_equalizer_gain,
		o_squelch, o_serial_out_off, o_recovered_clk_off, o_ddr_clk_on,
		o_data_invert, o_clk_invert, o_data_swing, o_clk_swing};

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	chk_phase_low_rate: assert property (
		!i_high_rate [*3] |-> o_sample_phase == 4'h0)
		else $error("phase offset not zero at low rate");
	chk_phase_hold: assert property (
		(i_high_rate && i_scl) [*4] |-> $stable(o_sample_phase))
		else $error("phase offset moved while bus idle");
	chk_slice_enable_word: assert property (
		$stable(o_slice_level) |-> o_slice_enable == (o_slice_level != 7'h0))
		else $error("slice enable does not match slice word");
	chk_swing_reset_code: assert property (
		$past(i_reset) |-> o_data_swing == 4'hc && o_clk_swing == 4'hc)
		else $error("swing codes not at default after reset");
	chk_control_reset_idle: assert property (
		$past(i_reset) |-> o_ddr_clk_on && !o_squelch && !o_serial_out_off
			&& !o_recovered_clk_off && !o_data_invert && !o_clk_invert)
		else $error("output controls not at default after reset");
	chk_cfg_hold_idle: assert property (
		!$stable(cfg) |-> !i_scl)
		else $error("configuration changed outside a write");
	chk_sda_edge_low: assert property (
		!$stable(o_sda_oe_n) |-> !i_scl)
		else $error("data pin drive changed while clock high");
	chk_open_drain_low: assert property (
		!o_sda_oe_n |-> o_sda_out == 1'b0)
		else $error("data pin driven high");

	cover property ($rose(o_data_invert));
	cover property ($rose(o_slice_enable));
	cover property (i_high_rate && o_sample_phase != 4'h0);
endmodule

`default_nettype wire

// >>> cdr_i2c_host.sv
`default_nettype none

module cdr_i2c_host (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output var logic  o_scl,
	output var logic  o_sda_low
);
	timeunit 1ns;
	timeprecision 1ps;

	// ten clocks keeps every phase above the eight-clock minimum
	localparam int half = 10;
	logic nack;

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		nack = 1'b0;
	end

	task automatic tick();
		repeat (half) @(posedge i_clk);
	endtask

	task automatic put_bit(input logic b);
		o_sda_low <= !b;
		tick();
		o_scl <= 1'b1;
		tick();
		o_scl <= 1'b0;
		tick();
	endtask

	// released line floats high through the pull-up
	task automatic get_bit(output logic b);
		o_sda_low <= 1'b0;
		tick();
		o_scl <= 1'b1;
		tick();
		b = i_sda;
		o_scl <= 1'b0;
		tick();
	endtask

	// also serves as repeated start from a low clock
	task automatic start();
		o_sda_low <= 1'b0;
		tick();
		o_scl <= 1'b1;
		tick();
		o_sda_low <= 1'b1;
		tick();
		o_scl <= 1'b0;
		tick();
	endtask

	task automatic stop();
		o_sda_low <= 1'b1;
		tick();
		o_scl <= 1'b1;
		tick();
		o_sda_low <= 1'b0;
		tick();
	endtask

	task automatic put_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(v[i]);
		get_bit(a);
		nack = nack | a;
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
			input logic [7:0] val);
		nack = 1'b0;
		start();
		put_byte({dev, 1'b0});
		put_byte(ofs);
		put_byte(val);
		stop();
	endtask

	// acks every byte but the last, which it nacks to end the burst
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
			input int n, output logic [15:0] val);
		logic b;
		nack = 1'b0;
		val = 16'h0000;
		start();
		put_byte({dev, 1'b0});
		put_byte(ofs);
		start();
		put_byte({dev, 1'b1});
		for (int i = 0; i < 8 * n; i++) begin
			get_bit(b);
			val = {val[14:0], b};
			if (i % 8 == 7)
				put_bit(i == 8 * n - 1);
		end
		stop();
	endtask
endmodule

`default_nettype wire

// >>> testbench.sv
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [6:0] dev_addr = 7'h40;

	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       high_rate = 1'b0;
	logic       scl, sda_low, sda_out, sda_oe_n, ext, en, term, auto_on;
	logic       squelch, ser_off, rclk_off, ddr_on, dinv, cinv;
	logic [1:0] sel;
	logic [3:0] phase, gain, dswing, cswing;
	logic [6:0] level;
	wire logic  sda;
	int         miscompares = 0;
	int         tests_run = 0;

	always #10 clk = ~clk;
	assign sda = !(sda_low || (!sda_oe_n && !sda_out));

	cdr_frontend_output_config_regs #(
		.DEV_ADDR(32'h0000_0040)
	) u_cdr_frontend_output_config_regs (
		.i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_high_rate(high_rate), .o_sample_phase(phase),
		.o_extended_slice(ext), .o_slice_level(level),
		.o_slice_enable(en), .o_term_float(term), .o_input_select(sel),
		.o_auto_boost_on(auto_on), .o_equalizer_gain(gain),
		.o_squelch(squelch), .o_serial_out_off(ser_off),
		.o_recovered_clk_off(rclk_off), .o_ddr_clk_on(ddr_on),
		.o_data_invert(dinv), .o_clk_invert(cinv),
		.o_data_swing(dswing), .o_clk_swing(cswing));

	cdr_i2c_host u_cdr_i2c_host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low));

	function automatic logic [7:0] ctrl_now();
		return {2'b00, squelch, ser_off, rclk_off, ~ddr_on, dinv, cinv};
	endfunction

	task automatic stop_test();
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
		u_cdr_i2c_host.write_reg(dev_addr, ofs, val);
		check("write ack", 8'h00, {7'h0, u_cdr_i2c_host.nack});
	endtask

	task automatic rd_check(input logic [7:0] ofs, input logic [7:0] exp);
		logic [15:0] got;
		u_cdr_i2c_host.read_reg(dev_addr, ofs, 1, got);
		check("readback", exp, got[7:0]);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults();
		check("phase", 8'h00, {4'h0, phase});
		check("slice", 8'h00, {ext, level});
		check("stage", 8'h00, {term, sel, auto_on, gain});
		check("control", 8'h00, ctrl_now());
		check("swing", 8'hcc, {dswing, cswing});
		rd_check(8'h1f, 8'hcc);
		rd_check(8'h16, 8'h00);
	endtask

	task automatic t_phase();
		wr(8'h14, 8'h09);
		check("phase low rate", 8'h00, {4'h0, phase});
		high_rate <= 1'b1;
		repeat (4) @(posedge clk);
		check("phase high rate", 8'h09, {4'h0, phase});
		rd_check(8'h14, 8'h09);
	endtask

	task automatic t_slice();
		wr(8'h15, 8'h80);
		check("slice", 8'h80, {ext, level});
		check("slice enable", 8'h00, {7'h0, en});
		wr(8'h15, 8'h01);
		check("slice", 8'h01, {ext, level});
		check("slice enable", 8'h01, {7'h0, en});
	endtask

	// adaptive only with the rate qualifier high; code 11 never sent
	task automatic t_stage();
		logic [7:0] vals [3] = '{8'h9a, 8'h25, 8'hcf};
		foreach (vals[i]) begin
			wr(8'h16, vals[i]);
			check("stage", vals[i], {term, sel, auto_on, gain});
		end
	endtask

	task automatic t_control();
		for (int i = 0; i < 6; i++) begin
			wr(8'h1e, 8'h01 << i);
			check("control", 8'h01 << i, ctrl_now());
		end
	endtask

	task automatic t_swing();
		wr(8'h1f, 8'h4f);
		check("swing", 8'h4f, {dswing, cswing});
		rd_check(8'h1f, 8'h4f);
	endtask

	// two bytes in one read: host ack path and pointer increment
	task automatic t_burst();
		logic [15:0] got;
		u_cdr_i2c_host.read_reg(dev_addr, 8'h1e, 2, got);
		check("burst first", 8'h20, got[15:8]);
		check("burst second", 8'h4f, got[7:0]);
	endtask

	// a foreign address is left unanswered and changes nothing
	task automatic t_refuse();
		u_cdr_i2c_host.write_reg(7'h41, 8'h1f, 8'h00);
		check("foreign nack", 8'h01, {7'h0, u_cdr_i2c_host.nack});
		check("swing", 8'h4f, {dswing, cswing});
		rd_check(8'h20, 8'h00);
	endtask

	task automatic t_retain();
		rd_check(8'h1e, 8'h20);
		rd_check(8'h16, 8'hcf);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		check("swing", 8'hcc, {dswing, cswing});
		check("control", 8'h00, ctrl_now());
		rd_check(8'h15, 8'h00);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		t_defaults();
		t_phase();
		t_slice();
		t_stage();
		t_control();
		t_swing();
		t_burst();
		t_refuse();
		t_retain();
		stop_test();
	end

	// about twice the expected run length
	initial begin
		repeat (50000) @(posedge clk);
		miscompares++;
		stop_test();
	end
endmodule

bind cdr_frontend_output_config_regs cdr_cfg_checker u_cdr_cfg_checker (
	.i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl),
	.o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
	.i_high_rate(i_high_rate), .o_sample_phase(o_sample_phase),
	.o_extended_slice(o_extended_slice), .o_slice_level(o_slice_level),
	.o_slice_enable(o_slice_enable), .o_term_float(o_term_float),
	.o_input_select(o_input_select), .o_auto_boost_on(o_auto_boost_on),
	.o_equalizer_gain(o_equalizer_gain), .o_squelch(o_squelch),
	.o_serial_out_off(o_serial_out_off),
	.o_recovered_clk_off(o_recovered_clk_off),
	.o_ddr_clk_on(o_ddr_clk_on), .o_data_invert(o_data_invert),
	.o_clk_invert(o_clk_invert), .o_data_swing(o_data_swing),
	.o_clk_swing(o_clk_swing));

`default_nettype wire
